// ---- hscd_defines.svh ----
`ifndef HSCD_DEFINES_SVH
`define HSCD_DEFINES_SVH

// ----------------------------------------------------------------
// Strap field positions
// ----------------------------------------------------------------
`define HSCD_STRAP_W        16
`define HSCD_STRAP_BUS8     0
`define HSCD_STRAP_PROTO_LO 1
`define HSCD_STRAP_PROTO_HI 3
`define HSCD_STRAP_WAITPOL  5

// ----------------------------------------------------------------
// Codes, widths and register offsets
// ----------------------------------------------------------------
`define HSCD_PROTO_GENERIC  3'h3
`define HSCD_ADDR_W         21
`define HSCD_REG_AW         6
`define HSCD_DIS_OFFSET     6'h1B
`define HSCD_DIS_BIT        7
`define HSCD_DIS_RESET      16'h8000
`define HSCD_GPIO_OFFSET    6'h1E
`define HSCD_MISC_OFFSET    6'h20
`define HSCD_MISC_GPO_BIT   0
`define HSCD_MISC_PANEL_BIT 1

// ----------------------------------------------------------------
// Timing counts in core clock cycles
// ----------------------------------------------------------------
`define HSCD_HOST_SETTLE    3'h4
`define HSCD_HOST_RECOVER   3'h6

`endif

// ---- hscd_pkg.sv ----
package hscd_pkg;

  // Captured strap word, laid out bit for bit as sampled
  typedef struct packed {
    logic [4:0] reserved;
    logic       panel_active_low;
    logic       suspend_is_gpo;
    logic       dac_pins_gpio;
    logic [1:0] mem_type;
    logic       wait_active_high;
    logic       little_endian;
    logic [2:0] protocol;
    logic       bus8;
  } hscd_cfg_t;

  typedef enum logic [1:0] {D_IDLE, D_REG, D_MEM, D_HOLD} hscd_dev_state_t;

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_RELEASE} hscd_host_state_t;

endpackage : hscd_pkg

// ---- hscd_bus_if.sv ----
`include "hscd_defines.svh"

interface hscd_bus_if;
  logic                      cs_n;
  logic                      mem_sel;
  logic [`HSCD_ADDR_W-1:0]   addr;
  logic [15:0]               host_d_out;
  logic                      host_d_oe;
  logic [15:0]               dev_d_out;
  logic                      dev_d_oe;
  logic [15:0]               data;
  logic                      low_byte_write_en_n;
  logic                      high_byte_write_en_n;
  logic                      low_byte_read_en_n;
  logic                      high_byte_read_en_n;
  logic                      bus_status_in;
  logic                      wait_pin;
  logic [`HSCD_STRAP_W-1:0]  strap;

  // Shared data wire: the device wins while it drives
  assign data = dev_d_oe ? dev_d_out : host_d_out;

  modport dev (
    input  cs_n, mem_sel, addr, data, low_byte_write_en_n, high_byte_write_en_n,
    input  low_byte_read_en_n, high_byte_read_en_n, bus_status_in, strap,
    output dev_d_out, dev_d_oe, wait_pin
  );

  modport host (
    output cs_n, mem_sel, addr, host_d_out, host_d_oe, low_byte_write_en_n,
    output high_byte_write_en_n, low_byte_read_en_n, high_byte_read_en_n,
    output bus_status_in, strap,
    input  data, wait_pin
  );
endinterface : hscd_bus_if

// ---- hscd_host.sv ----
`include "hscd_defines.svh"

module hscd_host
  import hscd_pkg::*;
(
  // Clock and reset
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST,
  // Link to the device
  hscd_bus_if.host                     BUS,
  // Board strap levels
  input  wire logic [15:0]             STRAP_VAL,
  // Request side
  input  wire logic                    REQ,
  input  wire logic                    REQ_WE,
  input  wire logic [21:0]             REQ_ADDR,
  input  wire logic [1:0]              REQ_BE,
  input  wire logic [15:0]             REQ_WDATA,
  output logic                         READY,
  output logic                         DONE,
  output logic [15:0]                  RDATA
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hscd_host_state_t state_q;
  logic [21:0]      addr_q;
  logic             we_q;
  logic [1:0]       be_q;
  logic [15:0]      wdata_q;
  logic [2:0]       cnt_q;
  logic [2:0]       wsync_q;
  logic             wait_f_q;
  logic             wait_pol_q;
  logic             done_q;
  logic [15:0]      rdata_q;

  // Wait pin is foreign: three stages, accepted when the last two agree
  wire wait_insert = wait_f_q ~^ wait_pol_q;
  wire in_cycle    = (state_q != H_IDLE);
  wire strobing    = (state_q == H_STROBE);

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Two region selects merged as an active-low OR
  wire cs_reg_n = ~(in_cycle & ~addr_q[21]);
  wire cs_buf_n = ~(in_cycle &  addr_q[21]);
  assign BUS.cs_n    = cs_reg_n & cs_buf_n;
  assign BUS.mem_sel = addr_q[21];
  assign BUS.addr    = addr_q[`HSCD_ADDR_W-1:0];
  // Full 16-bit lanes always; enables only on the matching direction
  assign BUS.low_byte_write_en_n  = ~(strobing & we_q & be_q[0]);
  assign BUS.high_byte_write_en_n = ~(strobing & we_q & be_q[1]);
  assign BUS.low_byte_read_en_n   = ~(strobing & ~we_q & be_q[0]);
  assign BUS.high_byte_read_en_n  = ~(strobing & ~we_q & be_q[1]);
  assign BUS.bus_status_in = 1'b1;
  assign BUS.host_d_out    = wdata_q;
  assign BUS.host_d_oe     = in_cycle & we_q;
  assign BUS.strap         = STRAP_VAL;
  assign READY = (state_q == H_IDLE) & ~RST;
  assign DONE  = done_q;
  assign RDATA = rdata_q;

  // Wait synchroniser and agreement filter; polarity frozen in reset,
  // since the strap lines are free to move once the device has them
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wsync_q    <= 3'h0;
      wait_f_q   <= 1'b0;
      wait_pol_q <= STRAP_VAL[`HSCD_STRAP_WAITPOL];
    end else begin
      wsync_q <= {wsync_q[1:0], BUS.wait_pin};
      if (wsync_q[1] == wsync_q[2]) begin
        wait_f_q <= wsync_q[2];
      end
    end
  end

  // One single cycle at a time, ended only by the wait pin
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= H_IDLE;
      addr_q  <= 22'h000000;
      we_q    <= 1'b0;
      be_q    <= 2'h0;
      wdata_q <= 16'h0000;
      cnt_q   <= 3'h0;
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (REQ) begin
            addr_q  <= REQ_ADDR;
            we_q    <= REQ_WE;
            be_q    <= REQ_BE;
            wdata_q <= REQ_WDATA;
            state_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          cnt_q   <= 3'h0;
          state_q <= H_STROBE;
        end
        H_STROBE: begin
          // Settle lets the device's wait reach this side first
          if (cnt_q != `HSCD_HOST_SETTLE) begin
            cnt_q <= cnt_q + 3'h1;
          end else if (!wait_insert) begin
            rdata_q <= BUS.data;
            cnt_q   <= 3'h0;
            state_q <= H_RELEASE;
          end
        end
        H_RELEASE: begin
          // Recovery lets the device see the strobes go away
          if (cnt_q == `HSCD_HOST_RECOVER) begin
            done_q  <= 1'b1;
            state_q <= H_IDLE;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

endmodule : hscd_host

// ---- hscd_device.sv ----
`include "hscd_defines.svh"

module hscd_device
  import hscd_pkg::*;
#(
  parameter int BUF_AW = `HSCD_ADDR_W,
  parameter int REG_AW = `HSCD_REG_AW
) (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  // Host link
  hscd_bus_if.dev                BUS,
  // Display memory controller side
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic [BUF_AW-2:0]      MEM_ADDR,
  output logic [1:0]             MEM_BE,
  output logic [15:0]            MEM_WDATA,
  input  wire logic [15:0]       MEM_RDATA,
  input  wire logic              MEM_ACK,
  // Captured configuration
  output hscd_cfg_t              CFG,
  output logic                   CFG_BUS8,
  output logic [1:0]             CFG_MEM_TYPE,
  output logic                   CFG_PROTO_VALID,
  // Alternate pin functions
  input  wire logic [7:0]        DAC_IN,
  output logic [7:0]             GP_PINS_OUT,
  output logic [7:0]             GP_PINS_OE,
  input  wire logic              SUSPEND_PIN_IN_N,
  output logic                   SUSPEND_PIN_OUT,
  output logic                   SUSPEND_PIN_OE,
  output logic                   SUSPEND_REQ,
  output logic                   PANEL_POWER_OUT
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (REG_AW != `HSCD_REG_AW || BUF_AW < 2 || BUF_AW > `HSCD_ADDR_W) begin : g_chk
    $error("hscd_device: unsupported address widths");
  end

  localparam int NREG = 2 ** (REG_AW - 1);
  localparam int SW   = `HSCD_STRAP_W + 5;

  // Lane swap for big-endian hosts
  function automatic logic [15:0] swap16(input logic [15:0] v);
    swap16 = {v[7:0], v[15:8]};
  endfunction : swap16

  // Word index of a byte offset in the register window
  function automatic logic [REG_AW-2:0] widx(input logic [REG_AW-1:0] off);
    widx = off[REG_AW-1:1];
  endfunction : widx

  // ----------------------------------------------------------------
  // Synchronisers for straps, suspend pin and host controls
  // ----------------------------------------------------------------
  logic [SW-1:0] s1_q, s2_q, s3_q, f_q;
  logic          rst_q;
  hscd_cfg_t     cfg_q;

  wire [SW-1:0] raw_in = {BUS.strap, SUSPEND_PIN_IN_N, BUS.cs_n,
                          BUS.low_byte_write_en_n, BUS.high_byte_write_en_n,
                          BUS.low_byte_read_en_n};
  // High-byte read and the rest are folded below; the filter keeps a bit
  // until the last two stages agree, so a late edge never splits
  // No reset: straps must already be through the chain when reset falls
  always_ff @(posedge CORE_CLK) begin
    s1_q <= raw_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  logic [2:0] rd1_s_q;
  logic       rd1_f_q;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      f_q     <= '1;
      rd1_s_q <= 3'h7;
      rd1_f_q <= 1'b1;
    end else begin
      f_q     <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
      rd1_s_q <= {rd1_s_q[1:0], BUS.high_byte_read_en_n};
      if (rd1_s_q[1] == rd1_s_q[2]) begin
        rd1_f_q <= rd1_s_q[2];
      end
    end
  end

  // Strap word taken on the first cycle after reset falls
  always_ff @(posedge CORE_CLK) begin
    rst_q <= RST;
    if (RST) begin
      cfg_q <= '0;
    end else if (rst_q) begin
      cfg_q <= hscd_cfg_t'(s3_q[SW-1:5]);
    end
  end

  assign CFG             = cfg_q;
  assign CFG_BUS8        = cfg_q.bus8;
  assign CFG_MEM_TYPE    = cfg_q.mem_type;
  assign CFG_PROTO_VALID = (cfg_q.protocol == `HSCD_PROTO_GENERIC);

  // ----------------------------------------------------------------
  // Register file and access state
  // ----------------------------------------------------------------
  logic [15:0]     regs_q [0:NREG-1];
  hscd_dev_state_t state_q;
  logic            done_q;
  logic            we_q;
  logic            mem_q;
  logic [BUF_AW-1:0] addr_q;
  logic [1:0]      be_q;
  logic [15:0]     wdata_q;
  logic [15:0]     rdata_q;

  wire disabled = regs_q[widx(`HSCD_DIS_OFFSET)][8 + `HSCD_DIS_BIT];
  wire [7:0] gpio_word_dat = regs_q[widx(`HSCD_GPIO_OFFSET)][7:0];
  wire [7:0] gpio_word_dir = regs_q[widx(`HSCD_GPIO_OFFSET)][15:8];
  wire [15:0] misc_word    = regs_q[widx(`HSCD_MISC_OFFSET)];

  // Filtered strobes, active high
  wire f_cs  = ~f_q[3];
  wire f_we0 = ~f_q[2];
  wire f_we1 = ~f_q[1];
  wire f_rd0 = ~f_q[0];
  wire f_rd1 = ~rd1_f_q;
  wire f_any = f_cs & (f_we0 | f_we1 | f_rd0 | f_rd1);
  wire f_we  = f_we0 | f_we1;

  // Only the disable register answers while the port is disabled
  wire hits_dis = ~BUS.mem_sel &
                  (BUS.addr[REG_AW-1:1] == widx(`HSCD_DIS_OFFSET));
  wire ignore   = (disabled & ~hits_dis) | ~CFG_PROTO_VALID;

  // Wait pin from raw pins so it is asserted before the strobe is synchronised
  wire raw_any = ~BUS.cs_n & ~(BUS.low_byte_write_en_n & BUS.high_byte_write_en_n &
                 BUS.low_byte_read_en_n & BUS.high_byte_read_en_n);
  wire insert  = raw_any & ~ignore & ~done_q & ~RST & ~rst_q;
  assign BUS.wait_pin  = insert ^ ~cfg_q.wait_active_high;
  assign BUS.dev_d_out = rdata_q;
  assign BUS.dev_d_oe  = (state_q == D_HOLD) & ~we_q;

  // Lane mapping by width and byte order; status input left unread
  wire [1:0]  en_raw  = f_we ? {f_we1, f_we0} : {f_rd1, f_rd0};
  wire [1:0]  be_16   = cfg_q.little_endian ? en_raw : {en_raw[0], en_raw[1]};
  wire [1:0]  be_8    = BUS.addr[0] ? 2'h2 : 2'h1;
  wire [1:0]  be_in   = cfg_q.bus8 ? be_8 : be_16;
  wire [15:0] d_16    = cfg_q.little_endian ? BUS.data : swap16(BUS.data);
  wire [15:0] d_in    = cfg_q.bus8 ? {BUS.data[7:0], BUS.data[7:0]} : d_16;
  wire [15:0] rd_word = (state_q == D_MEM) ? MEM_RDATA : regs_q[addr_q[REG_AW-1:1]];
  wire [15:0] rd_16   = cfg_q.little_endian ? rd_word : swap16(rd_word);
  wire [15:0] rd_8    = addr_q[0] ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};
  wire [15:0] rd_out  = cfg_q.bus8 ? rd_8 : rd_16;

  // Buffer side handshake
  assign MEM_REQ   = (state_q == D_MEM);
  assign MEM_WE    = we_q;
  assign MEM_ADDR  = addr_q[BUF_AW-1:1];
  assign MEM_BE    = be_q;
  assign MEM_WDATA = wdata_q;

  // Access sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= D_IDLE;
      done_q  <= 1'b0;
      we_q    <= 1'b0;
      mem_q   <= 1'b0;
      addr_q  <= '0;
      be_q    <= 2'h0;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      case (state_q)
        D_IDLE: begin
          if (f_any && !ignore) begin
            we_q    <= f_we;
            mem_q   <= BUS.mem_sel;
            addr_q  <= BUS.addr[BUF_AW-1:0];
            be_q    <= be_in;
            wdata_q <= d_in;
            state_q <= BUS.mem_sel ? D_MEM : D_REG;
          end
        end
        D_REG: begin
          rdata_q <= rd_out;
          done_q  <= 1'b1;
          state_q <= D_HOLD;
        end
        D_MEM: begin
          if (MEM_ACK) begin
            rdata_q <= rd_out;
            done_q  <= 1'b1;
            state_q <= D_HOLD;
          end
        end
        D_HOLD: begin
          if (!f_any) begin
            done_q  <= 1'b0;
            state_q <= D_IDLE;
          end
        end
        default: state_q <= D_IDLE;
      endcase
    end
  end

  // Register writes, byte by byte; aliasing comes from the short index
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= 16'h0000;
      end
      regs_q[widx(`HSCD_DIS_OFFSET)] <= `HSCD_DIS_RESET;
    end else if (state_q == D_REG && we_q) begin
      for (int b = 0; b < 2; b++) begin
        if (be_q[b]) begin
          regs_q[addr_q[REG_AW-1:1]][8*b +: 8] <= wdata_q[8*b +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Alternate pin functions
  // ----------------------------------------------------------------
  assign GP_PINS_OUT     = cfg_q.dac_pins_gpio ? gpio_word_dat : DAC_IN;
  assign GP_PINS_OE      = cfg_q.dac_pins_gpio ? gpio_word_dir : 8'hFF;
  assign SUSPEND_PIN_OE  = cfg_q.suspend_is_gpo;
  assign SUSPEND_PIN_OUT = misc_word[`HSCD_MISC_GPO_BIT];
  assign SUSPEND_REQ     = ~cfg_q.suspend_is_gpo & ~f_q[4];
  // Polarity applied after the on bit so software sees logical sense
  assign PANEL_POWER_OUT = misc_word[`HSCD_MISC_PANEL_BIT] ^ cfg_q.panel_active_low;

endmodule : hscd_device

// ---- hscd_props.sv ----
`include "hscd_defines.svh"

module hscd_props (
  // Clock and reset
  input wire logic                     CORE_CLK,
  input wire logic                     RST,
  // Link signals
  input wire logic                     cs_n,
  input wire logic                     mem_sel,
  input wire logic [`HSCD_ADDR_W-1:0]  addr,
  input wire logic                     host_d_oe,
  input wire logic                     dev_d_oe,
  input wire logic                     low_byte_write_en_n,
  input wire logic                     high_byte_write_en_n,
  input wire logic                     low_byte_read_en_n,
  input wire logic                     high_byte_read_en_n,
  input wire logic                     bus_status_in,
  input wire logic                     wait_pin,
  input wire logic [`HSCD_STRAP_W-1:0] strap
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Own copy of the captured straps, so a later strap change is harmless
  logic        rst_q;
  logic [15:0] cap_q;
  always_ff @(posedge CORE_CLK) begin
    rst_q <= RST;
    if (rst_q && !RST) begin
      cap_q <= strap;
    end
  end

  // Strobe decode and wait meaning
  wire strb_w = !low_byte_write_en_n || !high_byte_write_en_n;
  wire strb_r = !low_byte_read_en_n || !high_byte_read_en_n;
  wire strb   = strb_w || strb_r;
  wire insert = (wait_pin == cap_q[`HSCD_STRAP_WAITPOL]);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  strobe_in_select_a: assert property (strb |-> !cs_n)
    else $error("strobe active without chip select");
  region_hold_a: assert property (!cs_n && $past(!cs_n) |-> $stable(mem_sel))
    else $error("region select moved inside a cycle");
  status_high_a: assert property (bus_status_in)
    else $error("bus status input not held high");
  write_only_a: assert property (strb_w |-> host_d_oe && !strb_r)
    else $error("write enable outside a write cycle");
  no_fight_a: assert property (!(host_d_oe && dev_d_oe))
    else $error("both ends drive the data wire");
  addr_hold_a: assert property (strb && $past(strb) |-> $stable(addr) && $stable(mem_sel))
    else $error("address changed during a single cycle");
  end_on_ready_a: assert property ($fell(strb) |-> !$past(insert))
    else $error("cycle ended while wait inserted");
  wait_bound_a: assert property (strb && insert |-> ##[1:80] !insert)
    else $error("wait held too long");
  read_drive_a: assert property ($rose(dev_d_oe) |-> strb_r && !cs_n)
    else $error("device drove data outside a read");
  wait_idle_a: assert property (cs_n && !rst_q |-> !insert)
    else $error("wait shown outside a cycle");

  // Main traffic kinds
  cover property (strb_w && mem_sel);
  cover property (strb_r && !mem_sel);
  cover property (strb && insert);
endmodule : hscd_props

// ---- hscd_tb.sv ----
module hscd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hscd_pkg::*;

  logic        clk, rst, req, req_we, ready, done, susp_n;
  logic        mem_req, mem_we, mem_ack, last_we, bus8, pvalid;
  logic        sus_out, sus_oe, sus_req, panel;
  logic [21:0] req_addr;
  logic [19:0] mem_addr, last_addr;
  logic [15:0] strap_val, req_wdata, rdata, mem_wdata, last_wd, acks, rv;
  logic [7:0]  gp_out, gp_oe;
  logic [1:0]  mem_be, mtype;
  logic [1:0]  mcnt;
  hscd_cfg_t   cfg;
  int          miscompares, samples_checked, cycles;

  // ----------------------------------------------------------------
  // Both ends across one link
  // ----------------------------------------------------------------
  hscd_bus_if u_hscd_bus_if ();

  hscd_host u_hscd_host (.CORE_CLK(clk), .RST(rst), .BUS(u_hscd_bus_if.host),
    .STRAP_VAL(strap_val), .REQ(req), .REQ_WE(req_we), .REQ_ADDR(req_addr),
    .REQ_BE(2'h3), .REQ_WDATA(req_wdata), .READY(ready), .DONE(done), .RDATA(rdata));

  hscd_device u_hscd_device (.CORE_CLK(clk), .RST(rst), .BUS(u_hscd_bus_if.dev),
    .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_BE(mem_be),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(16'hC3E1), .MEM_ACK(mem_ack), .CFG(cfg),
    .CFG_BUS8(bus8), .CFG_MEM_TYPE(mtype), .CFG_PROTO_VALID(pvalid), .DAC_IN(8'h96),
    .GP_PINS_OUT(gp_out), .GP_PINS_OE(gp_oe), .SUSPEND_PIN_IN_N(susp_n),
    .SUSPEND_PIN_OUT(sus_out), .SUSPEND_PIN_OE(sus_oe), .SUSPEND_REQ(sus_req),
    .PANEL_POWER_OUT(panel));

  hscd_props u_hscd_props (.CORE_CLK(clk), .RST(rst), .cs_n(u_hscd_bus_if.cs_n),
    .mem_sel(u_hscd_bus_if.mem_sel), .addr(u_hscd_bus_if.addr),
    .host_d_oe(u_hscd_bus_if.host_d_oe), .dev_d_oe(u_hscd_bus_if.dev_d_oe),
    .low_byte_write_en_n(u_hscd_bus_if.low_byte_write_en_n),
    .high_byte_write_en_n(u_hscd_bus_if.high_byte_write_en_n),
    .low_byte_read_en_n(u_hscd_bus_if.low_byte_read_en_n),
    .high_byte_read_en_n(u_hscd_bus_if.high_byte_read_en_n),
    .bus_status_in(u_hscd_bus_if.bus_status_in), .wait_pin(u_hscd_bus_if.wait_pin),
    .strap(u_hscd_bus_if.strap));

  // Memory model: acks three cycles in, so the wait path is really exercised
  always @(posedge clk) begin
    mcnt <= (rst || !mem_req) ? 2'h0 : mcnt + 2'h1;
    mem_ack <= !rst && mem_req && mcnt == 2'h2;
    if (rst) begin
      acks <= 16'h0;
    end else if (mem_ack) begin
      acks <= acks + 16'h1;
    end
    if (mem_req && mcnt == 2'h2) begin
      last_we <= mem_we;
      last_addr <= mem_addr;
      last_wd <= mem_wdata;
    end
  end

  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic [15:0] s);
    @(posedge clk);
    strap_val <= s;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // One host cycle; bounded waits so a dead link cannot hang the run
  task automatic host_op(input logic we, input logic [21:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    req_we <= we;
    req_addr <= a;
    req_wdata <= wd;
    #1;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 300);
    chk(16'(done), 16'h1);
    rv = rdata;
  endtask : host_op

  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_capture();
    chk(cfg, 16'hAFB6);
    chk(16'(mtype), 16'h2);
    @(posedge clk);
    strap_val <= 16'h5049;
    repeat (6) @(posedge clk);
    chk(cfg, 16'hAFB6);
  endtask : test_capture

  task automatic test_disable();
    host_op(1'b1, 22'h000010, 16'h1234);
    host_op(1'b0, 22'h00001A, 16'h0);
    chk(rv, 16'h8000);
    host_op(1'b1, 22'h00001A, 16'h0000);
    host_op(1'b0, 22'h000010, 16'h0);
    chk(rv, 16'h0000);
    host_op(1'b1, 22'h000010, 16'hA55A);
    host_op(1'b0, 22'h1FFFD0, 16'h0);
    chk(rv, 16'hA55A);
  endtask : test_disable

  task automatic test_buffer();
    host_op(1'b1, 22'h201234, 16'hBEEF);
    chk(16'(last_we), 16'h1);
    chk(last_addr[15:0], 16'h091A);
    chk(last_wd, 16'hBEEF);
    host_op(1'b0, 22'h200010, 16'h0);
    chk(rv, 16'hC3E1);
  endtask : test_buffer

  task automatic test_pins();
    host_op(1'b1, 22'h00001E, 16'hFF3C);
    chk({gp_oe, gp_out}, 16'hFF3C);
    host_op(1'b1, 22'h000020, 16'h0003);
    chk({14'h0, sus_oe, sus_out}, 16'h3);
    chk(16'(panel), 16'h0);
    host_op(1'b1, 22'h000020, 16'h0000);
    chk(16'(panel), 16'h1);
  endtask : test_pins

  // Big endian, active-low wait, all pins in their default roles
  task automatic test_alt_cfg();
    do_reset(16'h0006);
    chk({gp_oe, gp_out}, 16'hFF96);
    chk({14'h0, sus_oe, panel}, 16'h0);
    @(posedge clk);
    susp_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(16'(sus_req), 16'h1);
    susp_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(16'(sus_req), 16'h0);
    host_op(1'b0, 22'h00001A, 16'h0);
    chk(rv, 16'h0080);
    host_op(1'b1, 22'h00001A, 16'h0000);
    host_op(1'b1, 22'h200002, 16'h1122);
    chk(last_wd, 16'h2211);
    chk(last_addr[15:0], 16'h0001);
  endtask : test_alt_cfg

  // Every protocol code and both widths; last one is reserved
  task automatic test_protocols();
    logic [15:0] a;
    for (int p = 0; p < 8; p++) begin
      do_reset({12'h0, 3'(p), 1'(p)});
      chk(16'(pvalid), (p == 3) ? 16'h1 : 16'h0);
      chk(16'(bus8), 16'(p % 2));
      // Generic protocol in 8-bit mode: single lane, address bit 0 picks byte
      if (p == 3) begin
        host_op(1'b1, 22'h00001B, 16'h0000);
        host_op(1'b1, 22'h200005, 16'h005A);
        chk(last_wd, 16'h5A5A);
        chk(16'(mem_be), 16'h2);
        chk(last_addr[15:0], 16'h0002);
        host_op(1'b0, 22'h200001, 16'h0);
        chk(rv, 16'h00C3);
      end
    end
    a = acks;
    host_op(1'b1, 22'h00001A, 16'h0000);
    host_op(1'b1, 22'h200004, 16'h7777);
    chk(acks, a);
  endtask : test_protocols

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    strap_val = 16'hAFB6;
    req = 1'b0;
    req_we = 1'b0;
    req_addr = 22'h0;
    req_wdata = 16'h0;
    susp_n = 1'b1;
    do_reset(16'hAFB6);
    test_capture();
    test_disable();
    test_buffer();
    test_pins();
    test_alt_cfg();
    test_protocols();
    finish_test();
  end
endmodule : hscd_tb
